// >>> include/fbz_pkg.sv
/*
 * Package for the flash boot-zone and self-programming register block.
 * Holds register addresses, field positions, reset values and codes.
 * Assumes one core clock and a synchronous active-low reset.
 */
package fbz_pkg;
    // Register addresses in the direct special register space
    localparam logic [7:0] SFR_LOW_ADDR     = 8'h80;
    localparam logic [7:0] SYS_CONFIG_ADDR  = 8'hBF;
    localparam logic [7:0] FLASH_ADDR_HI    = 8'hF4;
    localparam logic [7:0] FLASH_ADDR_LO    = 8'hF5;
    localparam logic [7:0] FLASH_DATA_ADDR  = 8'hF6;
    localparam logic [7:0] FLASH_CTRL_ADDR  = 8'hF7;
    // Reset values
    localparam logic [7:0] SYS_CONFIG_RST   = 8'h0A;
    localparam logic [7:0] FLASH_REG_RST    = 8'h00;
    // System configuration fields
    localparam int WDOG_FLAG_BIT   = 7;
    localparam int DATA_FLASH_BIT  = 3;
    localparam int SELF_PROG_BIT   = 2;
    localparam int XRAM_BIT        = 1;
    localparam int LATCH_INH_BIT   = 0;
    localparam logic [7:0] SYS_CONFIG_RW_MASK = 8'h0F;
    // Operation control fields
    localparam int LAUNCH_BIT      = 7;
    localparam int REGION_BIT      = 5;
    localparam int FUNC_HI_BIT     = 1;
    localparam int FUNC_LO_BIT     = 0;
    // Unlock key bytes
    localparam logic [7:0] UNLOCK_KEY_A = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_B = 8'hAA;
    // Boot entry
    localparam logic [7:0]  BLANK_BYTE      = 8'hFF;
    localparam logic [3:0]  BOOT_SIZE_MAX   = 4'h8;
    localparam logic [16:0] PROG_FLASH_TOP  = 17'h10000;
    localparam int          BOOT_STEP_SHIFT = 9;
    // Function codes
    typedef enum logic [1:0] {
        FN_BYTE_PROG  = 2'h0,
        FN_ERASE_PROT = 2'h1,
        FN_PAGE_ERASE = 2'h2,
        FN_FULL_ERASE = 2'h3
    } fbz_func_e;
    // Unlock progress
    typedef enum logic [1:0] {UNL_IDLE, UNL_GOT_A, UNL_GOT_B, UNL_OPEN} fbz_unlock_e;
endpackage

// >>> core/fbz_flash_boot_regs.sv
/*
 * Flash boot-zone selection and self-programming registers.
 * Processor core writes/reads registers by direct address; the flash
 * array controller answers each request with a one-cycle done pulse.
 * Straps, size setting and lock option are static configuration inputs.
 */
`timescale 1ns/100ps

// How it works
// R1 - Only direct accesses reach registers 80h-FFh
// R2 - Program and data flash both self-programmable
// R3 - Boot zone sized 512B to 4KB steps
// R4 - Blank word zero plus size enters boot
// R5 - Low straps during reset enter boot
// R6 - Size zero disables boot entry entirely
// R7 - Programmer erase clears whole array always; flashKeepBoot drops only the cycle after flashEraseAll
// R8 - Lock protects boot zone, blocks readback
// R9 - Long jump may enter boot anytime
// R10 - Factory loader span treated as boot zone
// R11 - Region bit is seventeenth address bit
// R12 - Function code selects operation; locked erase
// R13 - Launch writable only after 55 AA 55
// R14 - Launch captures, holds PC, then clears
// R15 - Base is top minus size each cycle; vector sampled at release
// R16 - Flash registers zero after reset
module fbz_flash_boot_regs
    import fbz_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Special register access from the core
    input  wire logic [7:0]  sfrAddr,
    input  wire logic        sfrIndirect,
    input  wire logic        sfrWrite,
    input  wire logic        sfrRead,
    input  wire logic [7:0]  sfrWdata,
    output logic      [7:0]  sfrRdata,
    // Static configuration, straps and watchdog event
    input  wire logic [3:0]  bootZoneSizeSetting,
    input  wire logic        lockOption,
    input  wire logic [7:0]  word0Byte,
    input  wire logic        portP26,
    input  wire logic        portP27,
    input  wire logic        portP43,
    input  wire logic        watchdogResetEvent,
    // Boot entry results
    output logic             resetVectorValid,
    output logic      [15:0] resetVector,
    output logic      [15:0] bootZoneBase,
    // Flash array controller
    output logic             flashReq,
    output logic      [1:0]  flashFunc,
    output logic      [16:0] flashAddr,
    output logic      [7:0]  flashData,
    output logic             flashKeepBoot,
    input  wire logic        flashDone,
    input  wire logic        parallelErase,
    output logic             flashEraseAll,
    output logic             readbackBlock,
    // Core control and enables
    output logic             pcHold,
    output logic             dataFlashEnable,
    output logic             selfProgramEnable,
    output logic             expandedRamEnable,
    output logic             latchStrobeInhibit
);

    // Whole module state
    typedef struct packed {
        logic [7:0]  sysCfg;      // System configuration
        logic [7:0]  addrHi;      // Flash address high
        logic [7:0]  addrLo;      // Flash address low
        logic [7:0]  dataByte;    // Flash data byte
        logic        launch;      // Operation launch bit
        logic        region;      // Region select
        logic [1:0]  func;        // Function code
        fbz_unlock_e unlock;      // Key progress
        logic        busy;        // Operation running
        logic        req;         // Request pulse
        logic        issued;      // Request already sent
        logic [1:0]  opFunc;      // Captured function
        logic [16:0] opAddr;      // Captured address
        logic [7:0]  opData;      // Captured data
        logic        keepBoot;    // Erase spares boot zone
        logic        eraseAll;    // Programmer erase pulse
        logic        inReset;     // Reset seen last cycle
        logic        strapHeld;   // Straps low all through reset
        logic        vecValid;    // Vector computed
        logic [15:0] vector;      // Start address
        logic [15:0] base;        // Boot zone base
        logic        lockSeen;    // Registered lock
        logic [7:0]  rdata;       // Read answer
    } fbz_state_s;

    fbz_state_s st_r;   // Registered state
    fbz_state_s st_nxt; // Next state

    logic [3:0]  sizeClamp;  // Size limited to 4KB
    logic [16:0] baseWide;   // Top minus zone size
    logic        strapNow;   // Strap condition this cycle
    logic        direct;     // Direct access qualifier
    logic        inBoot;     // Captured address in boot zone
    logic        startOp;    // Launch waiting for its request
    logic        keepNow;    // Boot zone to be spared

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.req = 1'b0;
        st_nxt.eraseAll = 1'b0;
        // Zone base from size setting
        sizeClamp = (bootZoneSizeSetting > BOOT_SIZE_MAX) ? BOOT_SIZE_MAX
                                                          : bootZoneSizeSetting; // R3
        baseWide = PROG_FLASH_TOP - (17'(sizeClamp) << BOOT_STEP_SHIFT); // R15 R10
        strapNow = (!portP26 && !portP27) || !portP43;                   // R5
        direct = !sfrIndirect && (sfrAddr >= SFR_LOW_ADDR);              // R1
        inBoot = !st_r.opAddr[16] && (st_r.opAddr[15:0] >= st_r.base);
        st_nxt.base = baseWide[15:0];
        st_nxt.lockSeen = lockOption;                                    // R8
        st_nxt.inReset = !rstn;
        // Straps tracked over the whole reset pulse
        if (!rstn) begin
            st_nxt.strapHeld = st_r.inReset ? (st_r.strapHeld && strapNow) : strapNow; // R5
        end
        // Entry decision at reset release
        if (rstn && st_r.inReset) begin
            st_nxt.vecValid = 1'b1;
            if ((sizeClamp != 4'h0)
                && ((word0Byte == BLANK_BYTE) || st_r.strapHeld)) begin  // R4 R5 R6
                st_nxt.vector = baseWide[15:0];                          // R15
            end else begin
                st_nxt.vector = 16'h0000;                                // R6
            end
        end
        // Watchdog flag, set wins over clear
        if (sfrWrite && direct && sfrAddr == SYS_CONFIG_ADDR) begin
            st_nxt.sysCfg = (sfrWdata & SYS_CONFIG_RW_MASK)
                          | (st_r.sysCfg & sfrWdata & 8'h80);
        end
        if (watchdogResetEvent) begin
            st_nxt.sysCfg[WDOG_FLAG_BIT] = 1'b1;
        end
        // Register writes, blocked while an operation runs
        if (sfrWrite && direct && !st_r.busy) begin
            case (sfrAddr)
                FLASH_ADDR_HI: st_nxt.addrHi = sfrWdata;
                FLASH_ADDR_LO: st_nxt.addrLo = sfrWdata;
                FLASH_DATA_ADDR: begin
                    st_nxt.dataByte = sfrWdata;
                    // Key sequence tracking
                    case (st_r.unlock)
                        UNL_IDLE:  st_nxt.unlock = (sfrWdata == UNLOCK_KEY_A) ? UNL_GOT_A
                                                                              : UNL_IDLE; // R13
                        UNL_GOT_A: st_nxt.unlock = (sfrWdata == UNLOCK_KEY_B) ? UNL_GOT_B
                                   : (sfrWdata == UNLOCK_KEY_A) ? UNL_GOT_A : UNL_IDLE;   // R13
                        UNL_GOT_B: st_nxt.unlock = (sfrWdata == UNLOCK_KEY_A) ? UNL_OPEN
                                                                              : UNL_IDLE; // R13
                        UNL_OPEN:  st_nxt.unlock = UNL_OPEN;
                        default:   st_nxt.unlock = UNL_IDLE;
                    endcase
                end
                FLASH_CTRL_ADDR: begin
                    st_nxt.region = sfrWdata[REGION_BIT];                // R11
                    st_nxt.func = sfrWdata[FUNC_HI_BIT:FUNC_LO_BIT];     // R12
                    // Launch only once the key is complete
                    if (sfrWdata[LAUNCH_BIT] && st_r.unlock == UNL_OPEN
                        && st_r.sysCfg[SELF_PROG_BIT]
                        && (!sfrWdata[REGION_BIT] || st_r.sysCfg[DATA_FLASH_BIT])) begin // R13 R2
                        st_nxt.launch = 1'b1;
                        st_nxt.busy = 1'b1;                              // R14
                        st_nxt.unlock = UNL_IDLE;
                        st_nxt.opFunc = sfrWdata[FUNC_HI_BIT:FUNC_LO_BIT];
                        st_nxt.opAddr = {sfrWdata[REGION_BIT], st_r.addrHi, st_r.addrLo}; // R11 R14
                        st_nxt.opData = st_r.dataByte;                   // R14
                    end
                end
                default: begin
                end
            endcase
        end
        // One request pulse per launch; lock decides boot sparing
        startOp = st_r.busy && st_r.launch && !st_r.issued;
        keepNow = st_r.lockSeen && (st_r.opFunc == FN_FULL_ERASE
                  || (st_r.opFunc == FN_PAGE_ERASE && inBoot));          // R8 R12
        st_nxt.req = startOp;                                            // R14
        st_nxt.keepBoot = keepNow && !st_r.eraseAll;                     // R12 R7
        st_nxt.issued = st_r.busy && (st_r.issued || startOp);
        // Completion clears launch and frees the core
        if (st_r.busy && flashDone) begin
            st_nxt.busy = 1'b0;                                          // R14
            st_nxt.launch = 1'b0;                                        // R14
        end
        // Programmer erase pulses whatever the lock; keepBoot drops only the cycle after the pulse
        if (parallelErase) begin
            st_nxt.eraseAll = 1'b1;                                      // R7
        end
        // Read answer, next cycle
        st_nxt.rdata = 8'h00;
        if (sfrRead && direct) begin
            case (sfrAddr)
                SYS_CONFIG_ADDR: st_nxt.rdata = st_r.sysCfg;
                FLASH_ADDR_HI:   st_nxt.rdata = st_r.addrHi;
                FLASH_ADDR_LO:   st_nxt.rdata = st_r.addrLo;
                FLASH_DATA_ADDR: st_nxt.rdata = st_r.dataByte;
                FLASH_CTRL_ADDR: st_nxt.rdata = {st_r.launch, 1'b0, st_r.region,
                                                 3'b000, st_r.func};
                default:         st_nxt.rdata = 8'h00;
            endcase
        end
        // Reset values
        if (!rstn) begin
            st_nxt.sysCfg = SYS_CONFIG_RST;
            {st_nxt.addrHi, st_nxt.addrLo, st_nxt.dataByte} = {3{FLASH_REG_RST}}; // R16
            st_nxt.launch = 1'b0;                                        // R16
            st_nxt.region = 1'b0;
            st_nxt.func = 2'h0;
            st_nxt.unlock = UNL_IDLE;
            st_nxt.busy = 1'b0;
            st_nxt.opFunc = 2'h0;
            st_nxt.opAddr = 17'h00000;
            st_nxt.opData = 8'h00;
            st_nxt.eraseAll = 1'b0;
            st_nxt.req = 1'b0;
            st_nxt.keepBoot = 1'b0;
            st_nxt.issued = 1'b0;
            st_nxt.vecValid = 1'b0;
            st_nxt.vector = 16'h0000;
            st_nxt.rdata = 8'h00;
        end
    end

    // State register, the whole module state in one flop bank
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    // Outputs straight from flip-flops
    assign sfrRdata = st_r.rdata;
    assign resetVectorValid = st_r.vecValid;
    assign resetVector = st_r.vector;
    assign bootZoneBase = st_r.base;     // Fetch of this span is never gated  R9
    assign flashReq = st_r.req;
    assign flashKeepBoot = st_r.keepBoot;
    assign flashFunc = st_r.opFunc;
    assign flashAddr = st_r.opAddr;
    assign flashData = st_r.opData;
    assign flashEraseAll = st_r.eraseAll;
    assign readbackBlock = st_r.lockSeen;                                // R8
    assign pcHold = st_r.busy;                                           // R14
    assign dataFlashEnable = st_r.sysCfg[DATA_FLASH_BIT];
    assign selfProgramEnable = st_r.sysCfg[SELF_PROG_BIT];
    assign expandedRamEnable = st_r.sysCfg[XRAM_BIT];
    assign latchStrobeInhibit = st_r.sysCfg[LATCH_INH_BIT];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Key sequence steps
    sequence keyA; sfrWrite && !sfrIndirect && sfrAddr == FLASH_DATA_ADDR
                   && sfrWdata == UNLOCK_KEY_A && !st_r.busy; endsequence
    sequence keyB; sfrWrite && !sfrIndirect && sfrAddr == FLASH_DATA_ADDR
                   && sfrWdata == UNLOCK_KEY_B && !st_r.busy; endsequence
    sequence keyGap; !(sfrWrite && !sfrIndirect && sfrAddr == FLASH_DATA_ADDR); endsequence

    indirect_ignored_a: assert property (sfrWrite && sfrIndirect // R1
        |=> $stable({st_r.addrHi, st_r.addrLo, st_r.dataByte, st_r.func}))
        else $error("indirect write changed a register");
    unlock_opens_a: assert property (st_r.unlock == UNL_IDLE ##0 keyA ##1 keyGap ##1 keyB // R13
        ##1 keyGap ##1 keyA |=> st_r.unlock == UNL_OPEN)
        else $error("key sequence did not unlock");
    launch_locked_a: assert property (st_r.unlock != UNL_OPEN && !st_r.busy |=> !$rose(st_r.busy)) // R13
        else $error("launch accepted without key");
    pc_hold_a: assert property ($rose(st_r.busy) |=> flashReq && pcHold) // R14
        else $error("request or hold missing after launch");
    done_clears_a: assert property (st_r.busy && flashDone |=> !st_r.launch && !pcHold) // R14
        else $error("launch not cleared on done");
    size_zero_a: assert property ($rose(resetVectorValid) && bootZoneSizeSetting == 4'h0 // R6
        |-> resetVector == 16'h0000) else $error("boot entered with size zero");
    prog_erase_a: assert property (parallelErase |=> flashEraseAll) // R7
        else $error("programmer erase lost");
    locked_erase_a: assert property (startOp && !st_r.issued && lockOption && st_r.lockSeen // R12
        && st_r.opFunc == FN_FULL_ERASE && !st_r.eraseAll |=> flashKeepBoot)
        else $error("locked full erase does not spare boot zone");
    base_calc_a: assert property ($stable(bootZoneSizeSetting) && bootZoneSizeSetting == 4'h7 // R10
        |=> bootZoneBase == 16'hF200) else $error("boot base wrong");

endmodule

// >>> sim/fbz_flash_model.sv
/*
 * Behavioural flash array controller for the boot-zone register block.
 * Assumes the block's clk and synchronous active-low rstn.
 */
`timescale 1ns/100ps

module fbz_flash_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Request and completion
    input  wire logic flashReq,
    output logic      flashDone
);
    logic [3:0] cnt;   // Cycles left in the operation
    logic       slow;  // Alternates prompt and slow answers

    // One done pulse per request, delay 2 or 9 cycles
    always @(posedge clk) begin
        if (!rstn) begin
            cnt       <= 4'h0;
            slow      <= 1'b0;
            flashDone <= 1'b0;
        end else begin
            flashDone <= (cnt == 4'h1);
            if (flashReq) begin
                cnt  <= slow ? 4'h9 : 4'h2;
                slow <= ~slow;
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule

// >>> sim/tb_top.sv
/*
 * Testbench: the core side driven by sfr tasks, the flash side by a model.
 * Assumes 100 ns clock, synchronous active-low reset, static straps.
 */
`timescale 1ns/100ps

module tb_top
    import fbz_pkg::*;
;
    logic clk, rstn, ind, wr, rd, lock, w, p26, p27, p43, pErase, done;
    logic [7:0]  addr, wdata, rdata, word0;
    logic [3:0]  size;
    logic [15:0] vec, base;
    logic [16:0] fAddr;
    logic [7:0]  fData;
    logic [1:0]  fFunc;
    logic vecOk, req, keep, eraseAll, rbBlock, pcHold, dfe, spe, xre, lsi;
    int   err_count, tests_run;

    fbz_flash_boot_regs fbz_flash_boot_regs_i (.clk(clk), .rstn(rstn), .sfrAddr(addr),
        .sfrIndirect(ind), .sfrWrite(wr), .sfrRead(rd), .sfrWdata(wdata), .sfrRdata(rdata),
        .bootZoneSizeSetting(size), .lockOption(lock), .word0Byte(word0), .portP26(p26),
        .portP27(p27), .portP43(p43), .watchdogResetEvent(w), .resetVectorValid(vecOk),
        .resetVector(vec), .bootZoneBase(base), .flashReq(req), .flashFunc(fFunc),
        .flashAddr(fAddr), .flashData(fData), .flashKeepBoot(keep), .flashDone(done),
        .parallelErase(pErase), .flashEraseAll(eraseAll), .readbackBlock(rbBlock),
        .pcHold(pcHold), .dataFlashEnable(dfe), .selfProgramEnable(spe),
        .expandedRamEnable(xre), .latchStrobeInhibit(lsi));

    fbz_flash_model fbz_flash_model_i (.clk(clk), .rstn(rstn), .flashReq(req), .flashDone(done));

    // Clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Verdict and end of run
    task automatic report_and_stop();
        if (err_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Compare port values
    task automatic chk_out(input logic [16:0] got, input logic [16:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: port got %h expected %h", $time, got, exp);
        end
    endtask

    // Compare register read data
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: read got %h expected %h", $time, got, exp);
        end
    endtask

    // One register access, strobe for one cycle
    task automatic sfr(input logic isWr, input logic [7:0] a, d, input logic isInd);
        @(posedge clk) #10;
        wr = isWr; rd = ~isWr; addr = a; wdata = d; ind = isInd;
        @(posedge clk) #10;
        wr = 1'b0; rd = 1'b0; ind = 1'b0;
    endtask

    // Read and compare
    task automatic rdc(input logic [7:0] a, exp);
        sfr(1'b0, a, 8'h00, 1'b0);
        chk_reg(rdata, exp);
    endtask

    // Bounded wait for flashReq (0) or flashEraseAll (1)
    task automatic wait_sig(input int sel, input int lim, output logic seen);
        seen = 1'b0;
        for (int n = 0; n < lim && !seen; n++) begin
            @(posedge clk) #10;
            seen = (sel == 0) ? (req === 1'b1) : (eraseAll === 1'b1);
        end
    endtask

    // Reset with given straps, then check the start address
    task automatic rst_chk(input logic [3:0] sz, input logic [7:0] w0,
                           input logic [2:0] st, input logic [15:0] exp);
        @(posedge clk) #10;
        size = sz; word0 = w0; {p26, p27, p43} = st; rstn = 1'b0;
        repeat (2) @(posedge clk);
        #10 rstn = 1'b1;
        @(posedge clk) #10;
        {p26, p27, p43} = 3'b111;
        chk_out(vecOk, 1'b1);
        chk_out(vec, exp);
    endtask

    // Keyed launch and check of what reaches the flash side
    task automatic launch(input logic [7:0] hi, key3, input logic [1:0] fn,
                          input logic rg, ok, expKeep);
        logic seen;
        sfr(1'b1, FLASH_ADDR_HI, hi, 1'b0);
        sfr(1'b1, FLASH_ADDR_LO, 8'h34, 1'b0);
        sfr(1'b1, FLASH_DATA_ADDR, UNLOCK_KEY_A, 1'b0);
        sfr(1'b1, FLASH_DATA_ADDR, UNLOCK_KEY_B, 1'b0);
        sfr(1'b1, FLASH_DATA_ADDR, key3, 1'b0);
        sfr(1'b1, FLASH_CTRL_ADDR, {1'b1, 1'b0, rg, 3'b000, fn}, 1'b0);
        wait_sig(0, 6, seen);
        chk_out(seen, ok);
        if (seen) begin
            chk_out(fFunc, fn);
            chk_out(fAddr, {rg, hi, 8'h34});
            chk_out(fData, key3);
            chk_out(keep, expKeep);
            for (int n = 0; n < 20 && pcHold !== 1'b0; n++) @(posedge clk) #10;
        end
        chk_out(pcHold, 1'b0);
        rdc(FLASH_CTRL_ADDR, {2'b00, rg, 3'b000, fn});
    endtask

    // Main sequence
    initial begin
        {rstn, ind, wr, rd, lock, w, pErase} = 7'h00;
        {p26, p27, p43} = 3'b111;
        addr = 8'h00; wdata = 8'h00; word0 = 8'hFF; size = 4'h0;
        err_count = 0; tests_run = 0;
        rst_chk(4'h0, 8'hFF, 3'b110, 16'h0000);
        rst_chk(4'h8, 8'hFF, 3'b111, 16'hF000);
        rst_chk(4'h2, 8'h00, 3'b111, 16'h0000);
        rst_chk(4'h1, 8'hFF, 3'b111, 16'hFE00);
        rst_chk(4'h7, 8'hFF, 3'b111, 16'hF200);
        rst_chk(4'h2, 8'h00, 3'b110, 16'hFC00);
        rst_chk(4'h2, 8'h00, 3'b001, 16'hFC00);
        chk_out(base, 16'hFC00);
        rdc(SYS_CONFIG_ADDR, SYS_CONFIG_RST);
        for (int a = 4; a < 8; a++) rdc(8'hF0 + 8'(a), FLASH_REG_RST);
        chk_out({dfe, spe, xre, lsi}, 4'hA);
        sfr(1'b1, FLASH_ADDR_HI, 8'hA5, 1'b1);
        rdc(FLASH_ADDR_HI, 8'h00);
        sfr(1'b1, FLASH_ADDR_LO, 8'h5A, 1'b0);
        rdc(FLASH_ADDR_LO, 8'h5A);
        rdc(8'hF8, 8'h00);
        sfr(1'b1, SYS_CONFIG_ADDR, 8'hFF, 1'b0);
        rdc(SYS_CONFIG_ADDR, 8'h0F);
        chk_out({dfe, spe, xre, lsi}, 4'hF);
        @(posedge clk) #10 w = 1'b1;
        @(posedge clk) #10 w = 1'b0;
        rdc(SYS_CONFIG_ADDR, 8'h8F);
        sfr(1'b1, SYS_CONFIG_ADDR, 8'h08, 1'b0);
        launch(8'h12, UNLOCK_KEY_A, 2'h0, 1'b0, 1'b0, 1'b0);
        sfr(1'b1, SYS_CONFIG_ADDR, 8'h0C, 1'b0);
        rdc(SYS_CONFIG_ADDR, 8'h0C);
        for (int i = 0; i < 8; i++) begin
            lock = i[2];
            launch(8'h12, UNLOCK_KEY_A, i[1:0], i[2], 1'b1, i[2] & (i[1:0] == 2'h3));
        end
        launch(8'h12, 8'h56, 2'h0, 1'b0, 1'b0, 1'b0);
        launch(8'hFE, UNLOCK_KEY_A, 2'h2, 1'b0, 1'b1, 1'b1);
        chk_out(rbBlock, 1'b1);
        begin
            logic seen;
            @(posedge clk) #10 pErase = 1'b1;
            @(posedge clk) #10 pErase = 1'b0;
            chk_out(eraseAll, 1'b1);
            wait_sig(1, 1, seen);
            chk_out(seen, 1'b0);
        end
        lock = 1'b0;
        @(posedge clk) #10;
        @(posedge clk) #10;
        chk_out(rbBlock, 1'b0);
        report_and_stop();
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
endmodule
